// [src/pgp_pkg.sv]
// constants for the port A/C/D general-purpose I/O block
package pgp_pkg;
  // bus geometry
  localparam int PGP_AW = 8;
  localparam int PGP_DW = 32;
  localparam logic [7:0] PGP_MAP_END = 8'h40;
  localparam logic [1:0] PGP_RESP_OKAY = 2'h0;
  localparam logic [1:0] PGP_RESP_SLVERR = 2'h2;
  // register byte offsets
  localparam logic [7:0] PGP_OFF_PA_DATA = 8'h00;
  localparam logic [7:0] PGP_OFF_PA_DIR = 8'h04;
  localparam logic [7:0] PGP_OFF_PA_PIN = 8'h08;
  localparam logic [7:0] PGP_OFF_PC_DATA = 8'h0c;
  localparam logic [7:0] PGP_OFF_PC_DIR = 8'h10;
  localparam logic [7:0] PGP_OFF_PC_PIN = 8'h14;
  localparam logic [7:0] PGP_OFF_PD_DATA = 8'h18;
  localparam logic [7:0] PGP_OFF_PD_DIR = 8'h1c;
  localparam logic [7:0] PGP_OFF_PD_PIN = 8'h20;
  localparam logic [7:0] PGP_OFF_PULL_A = 8'h24;
  localparam logic [7:0] PGP_OFF_PULL_C = 8'h28;
  localparam logic [7:0] PGP_OFF_MISC = 8'h2c;
  localparam logic [7:0] PGP_OFF_WAKE_A = 8'h30;
  localparam logic [7:0] PGP_OFF_PWR = 8'h34;
  localparam logic [7:0] PGP_OFF_STAT = 8'h38;
  localparam logic [7:0] PGP_OFF_MASK = 8'h3c;
  // reset values
  localparam logic [7:0] PGP_RST_BYTE = 8'h00;
  localparam logic [7:0] PGP_RST_PC_DATA = 8'h0c;
  localparam logic [3:0] PGP_RST_NIB = 4'h0;
  localparam logic [1:0] PGP_RST_PWR = 2'h0;
  // misc configuration bits
  localparam int PGP_MISC_PD_LO = 0;
  localparam int PGP_MISC_PD_HI = 1;
  localparam int PGP_MISC_AUD = 2;
  localparam int PGP_MISC_MFI = 3;
  // power control bits
  localparam int PGP_PWR_IDLE = 0;
  localparam int PGP_PWR_DOWN = 1;
  // status / mask bits
  localparam int PGP_ST_PC0 = 0;
  localparam int PGP_ST_PC5 = 1;
  localparam int PGP_ST_PC7 = 2;
  localparam int PGP_ST_WAKE = 3;
  // port C bit positions
  localparam int PGP_PC_BIT0_PIN = 0;
  localparam int PGP_PC_BIT5_PIN = 5;
  localparam int PGP_PC_BIT7_PIN = 7;
  localparam int PGP_PC_BIT2_OPEN_DRAIN = 2;
  localparam int PGP_PC_BIT3_OPEN_DRAIN = 3;
  localparam logic [7:0] PGP_PC_OD_MASK = 8'h0c;
  localparam logic [7:0] PGP_PC_AUD_MASK = 8'h02;
  localparam logic [7:0] PGP_PC_PULL_MASK = 8'hf3;
  // edge detector warm-up after reset
  localparam logic [1:0] PGP_ARM_CNT = 2'h2;
endpackage

// [src/pgp_evt_if.sv]
// signals between the register core and the edge/wake detector
`timescale 1ns/1ps
interface pgp_evt_if;
  logic [7:0] pc_lvl;
  logic [7:0] pa_lvl;
  logic [7:0] wake_en;
  logic mfi_en;
  logic pd;
  logic [2:0] pc_evt;
  logic pa_wake;
  logic armed;
  modport core (output pc_lvl, pa_lvl, wake_en, mfi_en, pd,
                input pc_evt, pa_wake, armed);
  modport det (input pc_lvl, pa_lvl, wake_en, mfi_en, pd,
               output pc_evt, pa_wake, armed);
endinterface

// [src/pgp_edge.sv]
// edge detector for port C interrupts and port A wake-up
`timescale 1ns/1ps
module pgp_edge (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // detector side of the event interface
  pgp_evt_if.det ev
);
  logic [7:0] pc_prev_r;
  logic [7:0] pa_prev_r;
  logic [1:0] arm_r;
  logic armed;

  // previous samples hold reset zeros, so wait until two are real
  assign armed = (arm_r == pgp_pkg::PGP_ARM_CNT);
  assign ev.armed = armed;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_prev_r <= pgp_pkg::PGP_RST_BYTE;
      pa_prev_r <= pgp_pkg::PGP_RST_BYTE;
      arm_r <= 2'h0;
    end else if (ce) begin
      pc_prev_r <= ev.pc_lvl;
      pa_prev_r <= ev.pa_lvl;
      if (!armed) begin
        arm_r <= arm_r + 2'h1;
      end
    end
  end

  assign ev.pc_evt[pgp_pkg::PGP_ST_PC0] = armed && ev.mfi_en &&
    pc_prev_r[pgp_pkg::PGP_PC_BIT0_PIN] &&
    !ev.pc_lvl[pgp_pkg::PGP_PC_BIT0_PIN];
  assign ev.pc_evt[pgp_pkg::PGP_ST_PC5] = armed && ev.mfi_en &&
    pc_prev_r[pgp_pkg::PGP_PC_BIT5_PIN] &&
    !ev.pc_lvl[pgp_pkg::PGP_PC_BIT5_PIN];
  assign ev.pc_evt[pgp_pkg::PGP_ST_PC7] = armed && ev.mfi_en &&
    !pc_prev_r[pgp_pkg::PGP_PC_BIT7_PIN] &&
    ev.pc_lvl[pgp_pkg::PGP_PC_BIT7_PIN];

  // wake on falling edge of enabled port A pins
  assign ev.pa_wake = armed && ev.pd &&
    (|(ev.wake_en & pa_prev_r & ~ev.pa_lvl));
endmodule

// [src/pgp_top.sv]
// port A/C/D general-purpose I/O block with AXI4-Lite registers
// Functional notes
// - each port A pin can be enabled to wake from power-down.
// - per-pin direction; outputs other than PC2 and PC3 drive push-pull, inputs are sampled.
// - ports A and C have a separate pull-high enable per pin, except PC2 and PC3.
// - with interrupt enabled, PC0/PC5 fall or PC7 rise raises interrupt.
// - a port C edge interrupt ends idle mode.
// - PC2 and PC3 only pull low or release, never drive high.
// - port D pull-high is chosen per four-bit nibble.
// - PC1 can carry the audio output instead of general I/O.
// - every bidirectional line except PC2 and PC3 offers the pull-high option.
`timescale 1ns/1ps
module pgp_top #(
  parameter int AW = pgp_pkg::PGP_AW
) (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // axi4-lite write
  input wire logic [AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // port A
  input wire logic [7:0] PORT_A_PINS_IN,
  output logic [7:0] PORT_A_PINS_OUT,
  output logic [7:0] PORT_A_PINS_OE,
  output logic [7:0] PORT_A_PULL_EN,
  // port C
  input wire logic [7:0] PORT_C_PINS_IN,
  output logic [7:0] PORT_C_PINS_OUT,
  output logic [7:0] PORT_C_PINS_OE,
  output logic [7:0] PORT_C_PULL_EN,
  input wire logic AUD_DAC,
  // port D
  input wire logic [7:0] PORT_D_PINS_IN,
  output logic [7:0] PORT_D_PINS_OUT,
  output logic [7:0] PORT_D_PINS_OE,
  output logic [7:0] PORT_D_PULL_EN,
  // system
  output logic IRQ,
  output logic IDLE,
  output logic POWER_DOWN,
  output logic WAKE
);
  logic [7:0] pa_data_r, pa_dir_r, pc_data_r, pc_dir_r;
  logic [7:0] pd_data_r, pd_dir_r, pa_pull_r, pc_pull_r, wake_en_r;
  logic [7:0] pa_smp_r, pc_smp_r, pd_smp_r;
  logic [3:0] misc_r, stat_r, mask_r, stat_nxt, ev_bits;
  logic [1:0] pwr_r, pwr_nxt;
  logic [AW-1:0] awaddr_r;
  logic [31:0] wdata_r, rd_mux;
  logic [3:0] wstrb_r;
  logic aw_got_r, w_got_r, aw_got_nxt, w_got_nxt;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic bvalid_nxt, rvalid_nxt;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [7:0] pa_out_r, pa_oe_r, pc_out_r, pc_oe_r, pd_out_r, pd_oe_r;
  logic [7:0] pa_pl_r, pc_pl_r, pd_pl_r;
  logic irq_r, wake_r;

  function automatic logic is_mapped(input logic [AW-1:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a < AW'(pgp_pkg::PGP_MAP_END));
  endfunction

  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [7:0] off);
    hit = (a == AW'(off));
  endfunction

  pgp_evt_if evt();

  pgp_edge u_edge (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .ev(evt)
  );

  assign evt.pc_lvl = pc_smp_r;
  assign evt.pa_lvl = pa_smp_r;
  assign evt.wake_en = wake_en_r;
  assign evt.mfi_en = misc_r[pgp_pkg::PGP_MISC_MFI];
  assign evt.pd = pwr_r[pgp_pkg::PGP_PWR_DOWN];

  // write channel: address and data accepted in either order
  wire aw_hs = S_AXI_AWVALID && awready_r;
  wire w_hs = S_AXI_WVALID && wready_r;
  wire have_aw = aw_got_r || aw_hs;
  wire have_w = w_got_r || w_hs;
  wire do_wr = have_aw && have_w && !bvalid_r;
  wire [AW-1:0] wa = aw_hs ? S_AXI_AWADDR : awaddr_r;
  wire [31:0] wd = w_hs ? S_AXI_WDATA : wdata_r;
  wire [3:0] ws = w_hs ? S_AXI_WSTRB : wstrb_r;
  // registers are at most one byte wide, so only lane 0 matters
  wire wr_ok = do_wr && ws[0] && is_mapped(wa);
  wire we_pa_data = wr_ok && hit(wa, pgp_pkg::PGP_OFF_PA_DATA);
  wire we_pa_dir = wr_ok && hit(wa, pgp_pkg::PGP_OFF_PA_DIR);
  wire we_pc_data = wr_ok && hit(wa, pgp_pkg::PGP_OFF_PC_DATA);
  wire we_pc_dir = wr_ok && hit(wa, pgp_pkg::PGP_OFF_PC_DIR);
  wire we_pd_data = wr_ok && hit(wa, pgp_pkg::PGP_OFF_PD_DATA);
  wire we_pd_dir = wr_ok && hit(wa, pgp_pkg::PGP_OFF_PD_DIR);
  wire we_pull_a = wr_ok && hit(wa, pgp_pkg::PGP_OFF_PULL_A);
  wire we_pull_c = wr_ok && hit(wa, pgp_pkg::PGP_OFF_PULL_C);
  wire we_misc = wr_ok && hit(wa, pgp_pkg::PGP_OFF_MISC);
  wire we_wake = wr_ok && hit(wa, pgp_pkg::PGP_OFF_WAKE_A);
  wire we_pwr = wr_ok && hit(wa, pgp_pkg::PGP_OFF_PWR);
  wire we_stat = wr_ok && hit(wa, pgp_pkg::PGP_OFF_STAT);
  wire we_mask = wr_ok && hit(wa, pgp_pkg::PGP_OFF_MASK);

  assign aw_got_nxt = have_aw && !do_wr;
  assign w_got_nxt = have_w && !do_wr;
  assign bvalid_nxt = do_wr || (bvalid_r && !S_AXI_BREADY);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= pgp_pkg::PGP_RESP_OKAY;
    end else if (CE) begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awready_r <= !aw_got_nxt && !bvalid_nxt;
      wready_r <= !w_got_nxt && !bvalid_nxt;
      bvalid_r <= bvalid_nxt;
      if (do_wr) begin
        bresp_r <= is_mapped(wa) ? pgp_pkg::PGP_RESP_OKAY
                                 : pgp_pkg::PGP_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else if (CE) begin
      if (aw_hs) begin
        awaddr_r <= S_AXI_AWADDR;
      end
      if (w_hs) begin
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end
    end
  end

  // read channel: reads have no side effects
  wire ar_hs = S_AXI_ARVALID && arready_r;
  assign rvalid_nxt = ar_hs || (rvalid_r && !S_AXI_RREADY);

  always_comb begin
    rd_mux = 32'h0;
    case (S_AXI_ARADDR)
      AW'(pgp_pkg::PGP_OFF_PA_DATA): rd_mux = {24'h0, pa_data_r};
      AW'(pgp_pkg::PGP_OFF_PA_DIR): rd_mux = {24'h0, pa_dir_r};
      AW'(pgp_pkg::PGP_OFF_PA_PIN): rd_mux = {24'h0, pa_smp_r};
      AW'(pgp_pkg::PGP_OFF_PC_DATA): rd_mux = {24'h0, pc_data_r};
      AW'(pgp_pkg::PGP_OFF_PC_DIR): rd_mux = {24'h0, pc_dir_r};
      AW'(pgp_pkg::PGP_OFF_PC_PIN): rd_mux = {24'h0, pc_smp_r};
      AW'(pgp_pkg::PGP_OFF_PD_DATA): rd_mux = {24'h0, pd_data_r};
      AW'(pgp_pkg::PGP_OFF_PD_DIR): rd_mux = {24'h0, pd_dir_r};
      AW'(pgp_pkg::PGP_OFF_PD_PIN): rd_mux = {24'h0, pd_smp_r};
      AW'(pgp_pkg::PGP_OFF_PULL_A): rd_mux = {24'h0, pa_pull_r};
      AW'(pgp_pkg::PGP_OFF_PULL_C): rd_mux = {24'h0, pc_pull_r};
      AW'(pgp_pkg::PGP_OFF_MISC): rd_mux = {28'h0, misc_r};
      AW'(pgp_pkg::PGP_OFF_WAKE_A): rd_mux = {24'h0, wake_en_r};
      AW'(pgp_pkg::PGP_OFF_PWR): rd_mux = {30'h0, pwr_r};
      AW'(pgp_pkg::PGP_OFF_STAT): rd_mux = {28'h0, stat_r};
      AW'(pgp_pkg::PGP_OFF_MASK): rd_mux = {28'h0, mask_r};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= pgp_pkg::PGP_RESP_OKAY;
    end else if (CE) begin
      arready_r <= !rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_hs) begin
        rdata_r <= rd_mux;
        rresp_r <= is_mapped(S_AXI_ARADDR) ? pgp_pkg::PGP_RESP_OKAY
                                           : pgp_pkg::PGP_RESP_SLVERR;
      end
    end
  end

  // data latch written only by software
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pa_data_r <= pgp_pkg::PGP_RST_BYTE;
      pa_dir_r <= pgp_pkg::PGP_RST_BYTE;
      pc_data_r <= pgp_pkg::PGP_RST_PC_DATA;
      pc_dir_r <= pgp_pkg::PGP_RST_BYTE;
      pd_data_r <= pgp_pkg::PGP_RST_BYTE;
      pd_dir_r <= pgp_pkg::PGP_RST_BYTE;
      pa_pull_r <= pgp_pkg::PGP_RST_BYTE;
      pc_pull_r <= pgp_pkg::PGP_RST_BYTE;
      wake_en_r <= pgp_pkg::PGP_RST_BYTE;
      misc_r <= pgp_pkg::PGP_RST_NIB;
      mask_r <= pgp_pkg::PGP_RST_NIB;
    end else if (CE) begin
      if (we_pa_data) pa_data_r <= wd[7:0];
      if (we_pa_dir) pa_dir_r <= wd[7:0];
      if (we_pc_data) pc_data_r <= wd[7:0];
      if (we_pc_dir) pc_dir_r <= wd[7:0];
      if (we_pd_data) pd_data_r <= wd[7:0];
      if (we_pd_dir) pd_dir_r <= wd[7:0];
      if (we_pull_a) pa_pull_r <= wd[7:0];
      if (we_pull_c) pc_pull_r <= wd[7:0];
      if (we_wake) wake_en_r <= wd[7:0];
      if (we_misc) misc_r <= wd[3:0];
      if (we_mask) mask_r <= wd[3:0];
    end
  end

  // events: set wins over a write-one clear in the same cycle
  assign ev_bits = {evt.pa_wake, evt.pc_evt};
  assign stat_nxt = (stat_r & ~(we_stat ? wd[3:0] : 4'h0)) | ev_bits;

  // port C edge ends idle, port A wake ends power-down
  always_comb begin
    pwr_nxt = we_pwr ? wd[1:0] : pwr_r;
    if (|evt.pc_evt) begin
      pwr_nxt[pgp_pkg::PGP_PWR_IDLE] = 1'b0;
    end
    if (evt.pa_wake) begin
      pwr_nxt[pgp_pkg::PGP_PWR_DOWN] = 1'b0;
    end
  end

  wire idle_wake = pwr_r[pgp_pkg::PGP_PWR_IDLE] && (|evt.pc_evt);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      stat_r <= pgp_pkg::PGP_RST_NIB;
      pwr_r <= pgp_pkg::PGP_RST_PWR;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else if (CE) begin
      stat_r <= stat_nxt;
      pwr_r <= pwr_nxt;
      irq_r <= |(stat_nxt & mask_r);
      wake_r <= evt.pa_wake || idle_wake;
    end
  end

  // schmitt inputs sampled, outputs follow direction
  wire aud_sel = misc_r[pgp_pkg::PGP_MISC_AUD];
  // open-drain lines drive zero, enable only when data is low
  wire [7:0] pc_gpio_out = pc_data_r & ~pgp_pkg::PGP_PC_OD_MASK;
  wire [7:0] pc_gpio_oe = (pc_dir_r & ~pgp_pkg::PGP_PC_OD_MASK) |
                          (~pc_data_r & pgp_pkg::PGP_PC_OD_MASK);
  // audio output takes over PC1 as a driven output
  wire [7:0] pc_out_nxt = aud_sel ?
    ((pc_gpio_out & ~pgp_pkg::PGP_PC_AUD_MASK) |
     ({8{AUD_DAC}} & pgp_pkg::PGP_PC_AUD_MASK)) : pc_gpio_out;
  wire [7:0] pc_oe_nxt = aud_sel ?
    (pc_gpio_oe | pgp_pkg::PGP_PC_AUD_MASK) : pc_gpio_oe;
  wire [7:0] pd_pull_nxt = {{4{misc_r[pgp_pkg::PGP_MISC_PD_HI]}},
                            {4{misc_r[pgp_pkg::PGP_MISC_PD_LO]}}};

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pa_smp_r <= pgp_pkg::PGP_RST_BYTE;
      pc_smp_r <= pgp_pkg::PGP_RST_BYTE;
      pd_smp_r <= pgp_pkg::PGP_RST_BYTE;
      pa_out_r <= pgp_pkg::PGP_RST_BYTE;
      pa_oe_r <= pgp_pkg::PGP_RST_BYTE;
      pc_out_r <= pgp_pkg::PGP_RST_BYTE;
      pc_oe_r <= pgp_pkg::PGP_RST_BYTE;
      pd_out_r <= pgp_pkg::PGP_RST_BYTE;
      pd_oe_r <= pgp_pkg::PGP_RST_BYTE;
      pa_pl_r <= pgp_pkg::PGP_RST_BYTE;
      pc_pl_r <= pgp_pkg::PGP_RST_BYTE;
      pd_pl_r <= pgp_pkg::PGP_RST_BYTE;
    end else if (CE) begin
      pa_smp_r <= PORT_A_PINS_IN;
      pc_smp_r <= PORT_C_PINS_IN;
      pd_smp_r <= PORT_D_PINS_IN;
      pa_out_r <= pa_data_r;
      pa_oe_r <= pa_dir_r;
      pc_out_r <= pc_out_nxt;
      pc_oe_r <= pc_oe_nxt;
      pd_out_r <= pd_data_r;
      pd_oe_r <= pd_dir_r;
      // per-pin pull-high on A and C except PC2/PC3
      pa_pl_r <= pa_pull_r;
      pc_pl_r <= pc_pull_r & pgp_pkg::PGP_PC_PULL_MASK;
      pd_pl_r <= pd_pull_nxt;
    end
  end

  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY = wready_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;
  assign PORT_A_PINS_OUT = pa_out_r;
  assign PORT_A_PINS_OE = pa_oe_r;
  assign PORT_A_PULL_EN = pa_pl_r;
  assign PORT_C_PINS_OUT = pc_out_r;
  assign PORT_C_PINS_OE = pc_oe_r;
  assign PORT_C_PULL_EN = pc_pl_r;
  assign PORT_D_PINS_OUT = pd_out_r;
  assign PORT_D_PINS_OE = pd_oe_r;
  assign PORT_D_PULL_EN = pd_pl_r;
  assign IRQ = irq_r;
  assign IDLE = pwr_r[pgp_pkg::PGP_PWR_IDLE];
  assign POWER_DOWN = pwr_r[pgp_pkg::PGP_PWR_DOWN];
  assign WAKE = wake_r;

  wire mfi = misc_r[pgp_pkg::PGP_MISC_MFI];
  sequence s_pc0_fall;
    (CE && pc_smp_r[0]) ##1 (CE && !pc_smp_r[0] && mfi && evt.armed);
  endsequence
  sequence s_pc7_rise;
    (CE && !pc_smp_r[7]) ##1 (CE && pc_smp_r[7] && mfi && evt.armed);
  endsequence

  property p_pc0_fall;
    @(posedge CLK) disable iff (RST) s_pc0_fall |=> stat_r[0];
  endproperty
  a_pc0_fall: assert property (p_pc0_fall)
    else $error("pc0 falling edge not flagged");
  property p_pc7_rise;
    @(posedge CLK) disable iff (RST)
      s_pc7_rise |=> IRQ || !$past(mask_r[2]);
  endproperty
  a_pc7_rise: assert property (p_pc7_rise)
    else $error("pc7 rising edge did not raise irq");
  property p_no_mfi;
    @(posedge CLK) disable iff (RST) (CE && !mfi) |-> evt.pc_evt == 3'h0;
  endproperty
  a_no_mfi: assert property (p_no_mfi)
    else $error("port c event while interrupt disabled");
  property p_idle_wake;
    @(posedge CLK) disable iff (RST)
      (CE && IDLE && (|evt.pc_evt)) |=> !IDLE && WAKE;
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("idle not left on port c edge");
  property p_pa_wake;
    @(posedge CLK) disable iff (RST)
      (CE && POWER_DOWN && evt.pa_wake) |=> !POWER_DOWN && stat_r[3];
  endproperty
  a_pa_wake: assert property (p_pa_wake)
    else $error("port a wake did not end power-down");
  property p_od_low;
    @(posedge CLK) disable iff (RST)
      (PORT_C_PINS_OUT[3:2] == 2'h0) and
      (CE |=> PORT_C_PINS_OE[2] == !$past(pc_data_r[2]));
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("open-drain line driven high or enable wrong");
  property p_dir;
    @(posedge CLK) disable iff (RST)
      CE |=> PORT_A_PINS_OE == $past(pa_dir_r) &&
      PORT_A_PINS_OUT == $past(pa_data_r);
  endproperty
  a_dir: assert property (p_dir)
    else $error("port a output does not follow latch");
  property p_nibble;
    @(posedge CLK) disable iff (RST)
      (PORT_D_PULL_EN[3:0] == 4'h0 || PORT_D_PULL_EN[3:0] == 4'hf) &&
      (PORT_D_PULL_EN[7:4] == 4'h0 || PORT_D_PULL_EN[7:4] == 4'hf);
  endproperty
  a_nibble: assert property (p_nibble)
    else $error("port d pull not per nibble");
  property p_audio;
    @(posedge CLK) disable iff (RST)
      (CE && aud_sel) |=> PORT_C_PINS_OE[1] &&
      PORT_C_PINS_OUT[1] == $past(AUD_DAC);
  endproperty
  a_audio: assert property (p_audio)
    else $error("audio output not on pc1");
  property p_latch;
    @(posedge CLK) disable iff (RST)
      (CE && !we_pa_data) |=> $stable(pa_data_r);
  endproperty
  a_latch: assert property (p_latch)
    else $error("port a latch changed without a write");
  property p_pull_c;
    @(posedge CLK) disable iff (RST)
      CE |=> PORT_C_PULL_EN == ($past(pc_pull_r) & 8'hf3);
  endproperty
  a_pull_c: assert property (p_pull_c)
    else $error("port c pull enables wrong");
endmodule

// [verification/pgp_board.sv]
// board model: resolves the levels of one eight-bit port
`timescale 1ns/1ps
module pgp_board (
  // clock
  input wire logic clk,
  // device side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pull_en,
  // board side
  input wire logic [7:0] ext_drv,
  input wire logic [7:0] ext_val,
  output logic [7:0] lvl
);
  logic [7:0] last_r;
  // a floating line flips, so a stale level never reads as valid
  always_ff @(posedge clk) begin
    last_r <= lvl;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) lvl[i] = pin_out[i];
      else if (ext_drv[i]) lvl[i] = ext_val[i];
      else if (pull_en[i]) lvl[i] = 1'b1;
      else lvl[i] = ~last_r[i];
    end
  end
endmodule

// [verification/tb.sv]
// self-checking bench for the port A/C/D block
`timescale 1ns/1ps
module tb;
  logic clk, rst, aud, wake_seen, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, idle, pdn, wake;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] awaddr, araddr, a_val, c_val;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [7:0] a_in, a_out, a_oe, a_pu, c_in, c_out, c_oe, c_pu;
  logic [7:0] d_in, d_out, d_oe, d_pu;
  logic [7:0] ev_val [3];
  logic [31:0] ev_bit [3];
  int miscompares, checks_done;
  pgp_top u_dut (.CLK(clk), .RST(rst), .CE(1'b1),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PORT_A_PINS_IN(a_in), .PORT_A_PINS_OUT(a_out), .PORT_A_PINS_OE(a_oe),
    .PORT_A_PULL_EN(a_pu), .PORT_C_PINS_IN(c_in), .PORT_C_PINS_OUT(c_out),
    .PORT_C_PINS_OE(c_oe), .PORT_C_PULL_EN(c_pu), .AUD_DAC(aud),
    .PORT_D_PINS_IN(d_in), .PORT_D_PINS_OUT(d_out), .PORT_D_PINS_OE(d_oe),
    .PORT_D_PULL_EN(d_pu), .IRQ(irq), .IDLE(idle), .POWER_DOWN(pdn),
    .WAKE(wake));
  pgp_board u_ba (.clk(clk), .pin_out(a_out), .pin_oe(a_oe), .pull_en(a_pu),
    .ext_drv(8'hff), .ext_val(a_val), .lvl(a_in));
  pgp_board u_bc (.clk(clk), .pin_out(c_out), .pin_oe(c_oe), .pull_en(c_pu),
    .ext_drv(8'hff), .ext_val(c_val), .lvl(c_in));
  pgp_board u_bd (.clk(clk), .pin_out(d_out), .pin_oe(d_oe), .pull_en(d_pu),
    .ext_drv(8'h00), .ext_val(8'h00), .lvl(d_in));
  // the wake pulse lasts one cycle, so latch it
  always @(posedge clk) begin
    if (wake) wake_seen <= 1'b1;
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic limit(input logic done);
    if (!done) begin
      $display("[FAIL] bus wait expected 1 seen 0");
      miscompares++;
      print_verdict();
    end
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1;
        resp = bresp;
      end
    end
    limit(done);
  endtask
  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1'b1;
        resp = rresp;
        chk(nm, e, rdata);
      end
    end
    limit(done);
  endtask
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, aud, wake_seen} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    a_val = 8'hff;
    c_val = 8'hff;
    ev_val = '{8'h7e, 8'h5e, 8'hde};
    ev_bit = '{32'h1, 32'h2, 32'h4};
    miscompares = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd("pc_data", 8'h0c, 32'h0c);
    chk("c_oe", 8'h00, c_oe);
    a_val <= 8'h3c;
    wr(8'h00, 32'ha5);
    settle();
    chk("a_oe", 8'h00, a_oe);
    wr(8'h04, 32'h0f);
    settle();
    chk("a_out", 8'ha5, a_out);
    chk("a_oe", 8'h0f, a_oe);
    rd("pa_pin", 8'h08, 32'h35);
    wr(8'h24, 32'h5a);
    wr(8'h28, 32'hff);
    wr(8'h2c, 32'h1);
    settle();
    chk("a_pu", 8'h5a, a_pu);
    chk("c_pu", 8'hf3, c_pu);
    chk("d_pu", 8'h0f, d_pu);
    wr(8'h2c, 32'h2);
    settle();
    chk("d_pu", 8'hf0, d_pu);
    wr(8'h1c, 32'h0f);
    wr(8'h18, 32'h96);
    // lane 0 strobe low: the latch must keep its value
    wstrb <= 4'h0;
    wr(8'h18, 32'h00);
    wstrb <= 4'hf;
    settle();
    chk("d_oe", 8'h0f, d_oe);
    chk("d_out", 8'h96, d_out);
    rd("pd_pin", 8'h20, 32'hf6);
    wr(8'h10, 32'hff);
    wr(8'h0c, 32'h00);
    settle();
    chk("c_oe", 8'hff, c_oe);
    chk("c_out", 8'h00, c_out);
    wr(8'h0c, 32'hff);
    settle();
    chk("c_out", 8'hf3, c_out);
    chk("c_oe", 8'hf3, c_oe);
    wr(8'h2c, 32'h4);
    aud <= 1'b0;
    settle();
    chk("aud_lo", 1'b0, c_out[1]);
    aud <= 1'b1;
    settle();
    chk("aud_hi", 1'b1, c_out[1]);
    c_val <= 8'h7f;
    wr(8'h10, 32'h00);
    wr(8'h2c, 32'h8);
    wr(8'h3c, 32'h7);
    for (int i = 0; i < 3; i++) begin
      c_val <= ev_val[i];
      settle();
      chk("irq_set", 1'b1, irq);
      rd("stat", 8'h38, ev_bit[i]);
      wr(8'h38, ev_bit[i]);
      settle();
      chk("irq_clr", 1'b0, irq);
    end
    c_val <= 8'h5e;
    wr(8'h3c, 32'h0);
    wr(8'h34, 32'h1);
    settle();
    chk("idle", 1'b1, idle);
    wake_seen <= 1'b0;
    c_val <= 8'hde;
    settle();
    chk("idle", 1'b0, idle);
    chk("wake", 1'b1, wake_seen);
    chk("irq_mask", 1'b0, irq);
    rd("stat", 8'h38, 32'h4);
    a_val <= 8'hff;
    wr(8'h38, 32'hf);
    wr(8'h04, 32'h00);
    wr(8'h30, 32'h08);
    wr(8'h34, 32'h2);
    settle();
    chk("pdn", 1'b1, pdn);
    a_val <= 8'hfb;
    settle();
    chk("pdn", 1'b1, pdn);
    wake_seen <= 1'b0;
    a_val <= 8'hf3;
    settle();
    chk("pdn", 1'b0, pdn);
    chk("wake", 1'b1, wake_seen);
    rd("stat", 8'h38, 32'h8);
    rd("unmapped", 8'h40, 32'h0);
    chk("resp", pgp_pkg::PGP_RESP_SLVERR, resp);
    wr(8'h40, 32'h0);
    chk("bresp", pgp_pkg::PGP_RESP_SLVERR, resp);
    print_verdict();
  end
endmodule
